// file: pid_reg_pkg.sv
// shared constants, register map and carrier types of the process regulator
// assumes one 10 MHz clock; percentages are carried in 0.1 % steps
package pid_reg_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_MS = 10;
    localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [3:0] LOSS_TICKS = 4'ha;
    localparam int DIV_STEPS = 48;
    localparam int FULL_SCALE = 10000000;
    localparam logic [47:0] I_SCALE = 48'h2710;
    localparam logic [3:0] SRC_PID = 4'h6;
    localparam logic [4:0] REG_POL = 5'h00;
    localparam logic [4:0] REG_KP = 5'h01;
    localparam logic [4:0] REG_TI = 5'h02;
    localparam logic [4:0] REG_TD = 5'h03;
    localparam logic [4:0] REG_TS = 5'h04;
    localparam logic [4:0] REG_DB = 5'h05;
    localparam logic [4:0] REG_FILT = 5'h06;
    localparam logic [4:0] REG_LTHR = 5'h07;
    localparam logic [4:0] REG_LTIME = 5'h08;
    localparam logic [4:0] REG_FSRC = 5'h09;
    localparam logic [4:0] REG_STAT = 5'h0a;
    localparam logic [4:0] REG_MASK = 5'h0b;
    localparam logic [4:0] REG_OUT_LO = 5'h0c;
    localparam logic [4:0] REG_OUT_HI = 5'h0d;
    localparam logic [4:0] REG_ERR = 5'h0e;
    localparam logic [15:0] KP_RST = 16'h000a;
    localparam logic [15:0] TI_RST = 16'h000a;
    localparam logic [15:0] TD_RST = 16'h0000;
    localparam logic [15:0] TS_RST = 16'h0032;
    localparam logic [15:0] DB_RST = 16'h0000;
    localparam logic [15:0] FILT_RST = 16'h0000;
    localparam logic [15:0] LTHR_RST = 16'h0000;
    localparam logic [15:0] LTIME_RST = 16'h0064;
    localparam logic [3:0] FSRC_RST = 4'h0;
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic pol;
        logic [15:0] kp;
        logic [15:0] ti;
        logic [15:0] td;
        logic [15:0] tsmp;
        logic [15:0] db;
        logic [15:0] filt;
        logic [15:0] lthr;
        logic [15:0] ltime;
    } cfg_t;
    typedef enum logic [1:0] {PH_IDLE, PH_I, PH_D, PH_F} phase_t;
endpackage

// file: pid_tick.sv
// free-running divider giving a one-cycle enable pulse every CYC clocks
// assumes the single system clock and asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pid_tick import pid_reg_pkg::*; #(
    parameter int CYC = TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    output logic tick
);
    localparam int W = $clog2(CYC + 1);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } tick_st_t;
    tick_st_t s_reg, s_next;
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == W'(CYC - 1)) begin
            s_next.cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + W'(1);
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign tick = s_reg.tick;
endmodule // pid_tick
`default_nettype wire

// file: pid_divider.sv
// unsigned restoring divider, one quotient bit per clock
// assumes den is never zero; a new start aborts any division in progress
`timescale 1ns/1ps
`default_nettype none
module pid_divider import pid_reg_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [47:0] num,
    input wire logic [16:0] den,
    output logic [47:0] quo,
    output logic done
);
    typedef struct packed {
        logic [47:0] q;
        logic [16:0] r;
        logic [16:0] d;
        logic [5:0] cnt;
        logic busy;
        logic done;
    } div_st_t;
    div_st_t s_reg, s_next;
    logic [17:0] rs;
    always_comb begin
        s_next = s_reg;
        rs = {s_reg.r, s_reg.q[47]};
        s_next.done = 1'b0;
        if (start) begin
            s_next.q = num;
            s_next.r = '0;
            s_next.d = den;
            s_next.cnt = 6'(DIV_STEPS - 1);
            s_next.busy = 1'b1;
        end else if (s_reg.busy) begin
            if (rs >= {1'b0, s_reg.d}) begin
                s_next.r = 17'(rs - {1'b0, s_reg.d});
                s_next.q = {s_reg.q[46:0], 1'b1};
            end else begin
                s_next.r = rs[16:0];
                s_next.q = {s_reg.q[46:0], 1'b0};
            end
            s_next.cnt = s_reg.cnt - 6'h01;
            if (s_reg.cnt == 6'h00) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign quo = s_reg.q;
    assign done = s_reg.done;
endmodule // pid_divider
`default_nettype wire

// file: process_pid_regulator.sv
// process closed-loop regulator: setpoint and feedback in, frequency command out
// assumes synchronous inputs, a register port with one-cycle strobes, 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module process_pid_regulator import pid_reg_pkg::*; #(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire reg_req_t req,
    output logic [15:0] rdata,
    input wire logic [15:0] setpoint,
    input wire logic [15:0] feedback,
    output logic [23:0] freq_cmd,
    output logic loss_fault,
    output logic irq
);
    typedef struct packed {
        cfg_t cfg;
        logic [3:0] fsrc;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [15:0] rdata;
        logic [15:0] scnt;
        logic [3:0] lsub;
        logic [15:0] lcnt;
        phase_t ph;
        logic signed [16:0] e;
        logic signed [16:0] ep;
        logic signed [31:0] integ;
        logic signed [31:0] y;
        logic neg;
        logic dgo;
        logic [47:0] dnum;
        logic [16:0] dden;
        logic irq;
    } st_t;
    st_t s_reg, s_next;
    logic tick;
    logic div_done;
    logic [47:0] div_q;
    logic active;
    logic go;
    logic ev_done;
    logic ev_loss;
    logic signed [16:0] e_raw;
    logic signed [16:0] e_cur;
    logic signed [17:0] de;
    logic signed [49:0] qs;
    logic signed [49:0] acc;
    logic signed [32:0] diff;
    logic [32:0] dmag;

    function automatic logic [17:0] mag18(input logic signed [17:0] v);
        mag18 = v[17] ? 18'(-v) : 18'(v);
    endfunction

    function automatic logic signed [49:0] clamp(input logic signed [49:0] v, input logic signed [49:0] lo);
        if (v > 50'(FULL_SCALE)) begin
            clamp = 50'(FULL_SCALE);
        end else if (v < lo) begin
            clamp = lo;
        end else begin
            clamp = v;
        end
    endfunction

    function automatic logic [16:0] nz(input logic [16:0] v);
        nz = (v == 17'h00000) ? 17'h00001 : v;
    endfunction

    pid_tick #(.CYC(TICK_CYC)) pid_tick_inst (
        .mclk(mclk),
        .nrst(nrst),
        .tick(tick)
    );

    pid_divider pid_divider_inst (
        .mclk(mclk),
        .nrst(nrst),
        .start(s_reg.dgo),
        .num(s_reg.dnum),
        .den(s_reg.dden),
        .quo(div_q),
        .done(div_done)
    );

    always_comb begin
        s_next = s_reg;
        s_next.dgo = 1'b0;
        s_next.rdata = 16'h0000;
        go = 1'b0;
        ev_done = 1'b0;
        ev_loss = 1'b0;
        acc = '0;
        diff = '0;
        dmag = '0;
        de = '0;
        active = (s_reg.fsrc == SRC_PID);
        // the divider works on magnitudes; the sign of each quotient is put back here
        qs = s_reg.neg ? -$signed({2'b00, div_q}) : $signed({2'b00, div_q});
        // setpoint may be negative, feedback never is
        e_raw = $signed({setpoint[15], setpoint}) - $signed({1'b0, feedback});
        e_cur = s_reg.cfg.pol ? -e_raw : e_raw;

        // status bits clear only where a one is written
        if (req.wr) begin
            unique case (req.addr)
                REG_POL: s_next.cfg.pol = req.wdata[0];
                REG_KP: s_next.cfg.kp = req.wdata;
                REG_TI: s_next.cfg.ti = req.wdata;
                REG_TD: s_next.cfg.td = req.wdata;
                REG_TS: s_next.cfg.tsmp = req.wdata;
                REG_DB: s_next.cfg.db = req.wdata;
                REG_FILT: s_next.cfg.filt = req.wdata;
                REG_LTHR: s_next.cfg.lthr = req.wdata;
                REG_LTIME: s_next.cfg.ltime = req.wdata;
                REG_FSRC: s_next.fsrc = req.wdata[3:0];
                REG_STAT: s_next.stat = s_reg.stat & ~req.wdata[1:0];
                REG_MASK: s_next.mask = req.wdata[1:0];
                default: ;
            endcase
        end

        if (req.rd) begin
            unique case (req.addr)
                REG_POL: s_next.rdata = {15'h0000, s_reg.cfg.pol};
                REG_KP: s_next.rdata = s_reg.cfg.kp;
                REG_TI: s_next.rdata = s_reg.cfg.ti;
                REG_TD: s_next.rdata = s_reg.cfg.td;
                REG_TS: s_next.rdata = s_reg.cfg.tsmp;
                REG_DB: s_next.rdata = s_reg.cfg.db;
                REG_FILT: s_next.rdata = s_reg.cfg.filt;
                REG_LTHR: s_next.rdata = s_reg.cfg.lthr;
                REG_LTIME: s_next.rdata = s_reg.cfg.ltime;
                REG_FSRC: s_next.rdata = {12'h000, s_reg.fsrc};
                REG_STAT: s_next.rdata = {14'h0000, s_reg.stat};
                REG_MASK: s_next.rdata = {14'h0000, s_reg.mask};
                REG_OUT_LO: s_next.rdata = s_reg.y[15:0];
                REG_OUT_HI: s_next.rdata = s_reg.y[31:16];
                REG_ERR: s_next.rdata = s_reg.e[15:0];
                default: s_next.rdata = 16'h0000;
            endcase
        end

        // sampling period in 10 ms ticks
        if (!active) begin
            s_next.scnt = 16'h0000;
        end else if (tick) begin
            if ({1'b0, s_reg.scnt} + 17'h00001 >= {1'b0, s_reg.cfg.tsmp}) begin
                s_next.scnt = 16'h0000;
                go = (s_reg.ph == PH_IDLE);
            end else begin
                s_next.scnt = s_reg.scnt + 16'h0001;
            end
        end

        // loss timer counts in 0.1 s steps and saturates
        if (!active || feedback > s_reg.cfg.lthr) begin
            s_next.lcnt = 16'h0000;
            s_next.lsub = 4'h0;
        end else if (tick) begin
            if (s_reg.lsub == LOSS_TICKS - 4'h1) begin
                s_next.lsub = 4'h0;
                if (s_reg.lcnt != 16'hffff) begin
                    s_next.lcnt = s_reg.lcnt + 16'h0001;
                end
            end else begin
                s_next.lsub = s_reg.lsub + 4'h1;
            end
        end
        // re-raised every cycle while the loss lasts, so a clear cannot hide it
        ev_loss = active && feedback <= s_reg.cfg.lthr && s_reg.lcnt > s_reg.cfg.ltime;

        unique case (s_reg.ph)
            PH_IDLE: begin
                if (go) begin
                    s_next.e = e_cur;
                    if (mag18(18'(e_cur)) <= {2'b00, s_reg.cfg.db}) begin
                        s_next.ep = e_cur;
                        ev_done = 1'b1;
                    end else begin
                        // integral step = e * T / Ti, scaled so full error reaches full scale in Ti
                        s_next.dnum = 48'(mag18(18'(e_cur))) * I_SCALE * 48'(s_reg.cfg.tsmp);
                        s_next.dden = nz({1'b0, s_reg.cfg.ti});
                        s_next.neg = e_cur[16];
                        s_next.dgo = 1'b1;
                        s_next.ph = PH_I;
                    end
                end
            end
            PH_I: begin
                if (div_done) begin
                    // the error is never zero here; the integral still holds when the quotient rounds to zero or it sits at the clamp
                    acc = $signed({{18{s_reg.integ[31]}}, s_reg.integ}) + qs;
                    s_next.integ = 32'(clamp(acc, -50'(FULL_SCALE)));
                    de = $signed({s_reg.e[16], s_reg.e}) - $signed({s_reg.ep[16], s_reg.ep});
                    s_next.dnum = 48'(mag18(de)) * I_SCALE * 48'(s_reg.cfg.td);
                    s_next.dden = nz({1'b0, s_reg.cfg.tsmp});
                    s_next.neg = de[17];
                    s_next.dgo = 1'b1;
                    s_next.ph = PH_D;
                end
            end
            PH_D: begin
                if (div_done) begin
                    // the integral is already updated, so all three terms see this sample
                    acc = 50'($signed({1'b0, s_reg.cfg.kp}) * s_reg.e)
                        + $signed({{18{s_reg.integ[31]}}, s_reg.integ}) + qs;
                    acc = clamp(acc, 50'sh0);
                    diff = 33'(acc) - $signed({s_reg.y[31], s_reg.y});
                    dmag = diff[32] ? 33'(-diff) : 33'(diff);
                    // first-order lag: y += (u - y) * T / (T + filter time)
                    s_next.dnum = 48'(dmag) * 48'(s_reg.cfg.tsmp);
                    s_next.dden = nz({1'b0, s_reg.cfg.tsmp} + {1'b0, s_reg.cfg.filt});
                    s_next.neg = diff[32];
                    s_next.dgo = 1'b1;
                    s_next.ph = PH_F;
                end
            end
            PH_F: begin
                if (div_done) begin
                    acc = $signed({{18{s_reg.y[31]}}, s_reg.y}) + qs;
                    s_next.y = 32'(clamp(acc, 50'sh0));
                    s_next.ep = s_reg.e;
                    s_next.ph = PH_IDLE;
                    ev_done = 1'b1;
                end
            end
        endcase

        if (!active) begin
            // leaving regulator mode drops any calculation and winds the loop down
            s_next.ph = PH_IDLE;
            s_next.integ = 32'sh0;
            s_next.y = 32'sh0;
            s_next.ep = 17'sh0;
            s_next.dgo = 1'b0;
        end

        // an event in the same cycle as its clear wins
        s_next.stat = s_next.stat | {ev_loss, ev_done};
        s_next.irq = |(s_next.stat & s_next.mask);
    end

    // reset loads the power-on settings with the regulator inactive
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.cfg.kp <= KP_RST;
            s_reg.cfg.ti <= TI_RST;
            s_reg.cfg.td <= TD_RST;
            s_reg.cfg.tsmp <= TS_RST;
            s_reg.cfg.db <= DB_RST;
            s_reg.cfg.filt <= FILT_RST;
            s_reg.cfg.lthr <= LTHR_RST;
            s_reg.cfg.ltime <= LTIME_RST;
            s_reg.fsrc <= FSRC_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output comes straight from the state register
    assign rdata = s_reg.rdata;
    assign freq_cmd = s_reg.y[23:0];
    assign loss_fault = s_reg.stat[1];
    assign irq = s_reg.irq;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_irq_level: assert property (|(s_reg.stat & s_reg.mask) |-> irq)
        else $error("interrupt low with unmasked status");
    a_read_one_cycle: assert property (!req.rd |=> rdata == 16'h0000)
        else $error("read data outside read slot");
    a_pos_sign: assert property (go && !s_reg.cfg.pol && e_raw < 0 |=> s_reg.e < 0)
        else $error("positive polarity sign wrong");
    a_neg_sign: assert property (go && s_reg.cfg.pol && e_raw < 0 |=> s_reg.e > 0)
        else $error("negative polarity sign wrong");
    a_dead_hold: assert property (go && mag18(18'(e_cur)) <= {2'b00, s_reg.cfg.db}
        |=> s_reg.ph == PH_IDLE && $stable(s_reg.y)) else $error("output moved inside deadband");
    a_mode_idle: assert property (s_reg.fsrc != SRC_PID |=> s_reg.y == 0 && s_reg.integ == 0)
        else $error("regulator ran outside its mode");
    a_loss_clear: assert property (active && feedback > s_reg.cfg.lthr |=> s_reg.lcnt == 0)
        else $error("loss timer not cleared");
    a_loss_raise: assert property (ev_loss |=> loss_fault)
        else $error("loss fault not raised");
    a_sample_bound: assert property (s_reg.cfg.tsmp != 0 |-> s_reg.scnt < s_reg.cfg.tsmp)
        else $error("sample counter past period");
    a_cmd_range: assert property (s_reg.y >= 0 && s_reg.y <= FULL_SCALE)
        else $error("command out of range");
    a_calc_order: assert property (active && s_reg.ph == PH_I && div_done |=> s_reg.ph == PH_D && s_reg.dgo)
        else $error("derivative step skipped");

    a_filter_order: assert property (active && s_reg.ph == PH_D && div_done |=> s_reg.ph == PH_F && s_reg.dgo)
        else $error("filter step skipped");

    a_calc_start: assert property (go && mag18(18'(e_cur)) > {2'b00, s_reg.cfg.db}
        |=> s_reg.ph == PH_I && s_reg.dgo) else $error("calculation not started");

    // the command moves only at the end of a calculation or when the mode is left
    a_cmd_quiet: assert property (active && !(s_reg.ph == PH_F && div_done) |=> $stable(s_reg.y))
        else $error("command moved between samples");

    a_integ_range: assert property (s_reg.integ >= -FULL_SCALE && s_reg.integ <= FULL_SCALE)
        else $error("integral wound past full scale");

    // one tenth of a second of low feedback adds one unit to the loss timer
    a_loss_step: assert property (active && tick && feedback <= s_reg.cfg.lthr
        && s_reg.lsub == LOSS_TICKS - 4'h1 && s_reg.lcnt != 16'hffff
        |=> s_reg.lcnt == $past(s_reg.lcnt) + 16'h0001) else $error("loss timer did not advance");

    a_fault_sticky: assert property (loss_fault && !(req.wr && req.addr == REG_STAT && req.wdata[1])
        |=> loss_fault) else $error("loss fault dropped without clear");

    a_irq_quiet: assert property (!(|(s_reg.stat & s_reg.mask)) |-> !irq)
        else $error("interrupt high with all status masked");

    c_sample_done: cover property (s_reg.ph == PH_F && div_done);
    c_deadband: cover property (go && s_reg.cfg.db != 0 && ev_done);
    c_loss_fault: cover property (ev_loss && !s_reg.stat[1]);
    c_loss_restart: cover property (active && s_reg.lcnt != 16'h0000 && feedback > s_reg.cfg.lthr);
    c_mode_leave: cover property (active && req.wr && req.addr == REG_FSRC && req.wdata[3:0] != SRC_PID);
endmodule // process_pid_regulator
`default_nettype wire

// file: pid_feedback_sensor.sv
// feedback sensor model: drives the measured feedback input of the regulator
// assumes the bench sets the wanted level; one clock of conversion latency
`timescale 1ns/1ps
`default_nettype none
module pid_feedback_sensor import pid_reg_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [15:0] level,
    output logic [15:0] feedback
);
    // own channel, never taken from the setpoint path, so the loop can close
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            feedback <= 16'h0000;
        end else if (level > 16'h03e8) begin
            feedback <= 16'h03e8;
        end else begin
            feedback <= level;
        end
    end
endmodule // pid_feedback_sensor
`default_nettype wire

// file: test_process_pid_regulator.sv
// self-checking bench of the process regulator: registers, regulation terms, loss monitor
// assumes the feedback sensor model; the tick is shortened to 10 clocks, a period to 200
`timescale 1ns/1ps
`default_nettype none
module test_process_pid_regulator import pid_reg_pkg::*;;
    localparam int TCYC = 10;
    localparam int TS = 20;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    reg_req_t req = '0;
    logic [15:0] rdata;
    logic [15:0] setpoint = 16'h0000;
    logic [15:0] fb_level = 16'h0000;
    logic [15:0] feedback;
    logic [23:0] freq_cmd;
    logic loss_fault;
    logic irq;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int last_t = 0;

    process_pid_regulator #(.TICK_CYC(TCYC)) process_pid_regulator_inst (.mclk(mclk), .nrst(nrst), .req(req),
        .rdata(rdata), .setpoint(setpoint), .feedback(feedback), .freq_cmd(freq_cmd), .loss_fault(loss_fault),
        .irq(irq));
    pid_feedback_sensor pid_feedback_sensor_inst (.mclk(mclk), .nrst(nrst), .level(fb_level), .feedback(feedback));

    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // completion is seen through the sample-done interrupt, then acknowledged
    task automatic wait_sample(output int dt);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 1000) begin
            check("sample done", 32'h0, 32'h1);
            finish_test();
        end
        dt = cyc - last_t;
        last_t = cyc;
        wr(REG_STAT, 16'h0001);
        @(posedge mclk);
        #1;
        check("irq after clear", {31'h0, irq}, 32'h0);
        @(posedge mclk);
    endtask

    // inactive first, so the integral and error history start from zero
    task automatic setup(input logic [15:0] v [7], input logic [15:0] sp, input logic [15:0] fb);
        wr(REG_FSRC, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            wr(5'(i), v[i]);
        end
        repeat (300) @(posedge mclk);
        check("inactive freq_cmd", {8'h00, freq_cmd}, 32'h0);
        setpoint <= sp;
        fb_level <= fb;
        wr(REG_STAT, 16'h0003);
        wr(REG_FSRC, {12'h000, SRC_PID});
        last_t = cyc;
    endtask

    task automatic t_regs();
        logic [15:0] d;
        logic [15:0] rst [12] = '{16'h0000, 16'h000a, 16'h000a, 16'h0000, 16'h0032, 16'h0000, 16'h0000,
            16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 12; i++) begin
            rd(5'(i), d);
            check("reset value", {16'h0, d}, {16'h0, rst[i]});
        end
        wr(5'h1f, 16'hffff);
        rd(5'h1f, d);
        check("unmapped read", {16'h0, d}, 32'h0);
        wr(REG_KP, 16'h0064);
        rd(REG_KP, d);
        check("gain readback", {16'h0, d}, 32'h64);
        @(posedge mclk);
        #1;
        check("rdata after read", {16'h0, rdata}, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_inactive();
        logic [15:0] d;
        logic [3:0] codes [3] = '{4'h5, 4'h7, 4'hf};
        setpoint <= 16'h03e8;
        for (int i = 0; i < 3; i++) begin
            wr(REG_FSRC, {12'h000, codes[i]});
            repeat (250) @(posedge mclk);
            #1;
            check("freq_cmd off", {8'h00, freq_cmd}, 32'h0);
            rd(REG_STAT, d);
            check("no sample", {16'h0, d}, 32'h0);
        end
        $display("test inactive done");
    endtask

    task automatic t_polarity();
        int dt;
        logic [15:0] d;
        setup('{16'h0000, 16'h2710, 16'h03e8, 16'h0000, 16'h0014, 16'h0000, 16'h0000}, 16'h03e8, 16'h0000);
        wait_sample(dt);
        check("full proportional", {8'h00, freq_cmd}, 32'd10000000);
        rd(REG_OUT_LO, d);
        check("output low", {16'h0, d}, 32'h9680);
        rd(REG_OUT_HI, d);
        check("output high", {16'h0, d}, 32'h0098);
        rd(REG_ERR, d);
        check("error readback", {16'h0, d}, 32'h03e8);
        setpoint <= 16'h00c8;
        fb_level <= 16'h012c;
        wait_sample(dt);
        check("positive polarity", {8'h00, freq_cmd}, 32'h0);
        setup('{16'h0001, 16'h2710, 16'h03e8, 16'h0000, 16'h0014, 16'h0000, 16'h0000}, 16'h00c8, 16'h012c);
        wait_sample(dt);
        check("negative polarity", {8'h00, freq_cmd}, 32'(100 * 10000 + 100 * 10000 * TS / 1000));
        $display("test polarity done");
    endtask

    // accumulate horizon of four periods: full error reaches maximum after four samples
    task automatic t_integral();
        int dt;
        setup('{16'h0000, 16'h0000, 16'h0050, 16'h0000, 16'h0014, 16'h0000, 16'h0000}, 16'h03e8, 16'h0000);
        wait_sample(dt);
        check("integral step", {8'h00, freq_cmd}, 32'd2500000);
        wait_sample(dt);
        check("integral grows", {8'h00, freq_cmd}, 32'd5000000);
        check("sample period", 32'(dt), 32'(TS * TCYC));
        setpoint <= 16'h0000;
        wait_sample(dt);
        check("integral stops", {8'h00, freq_cmd}, 32'd5000000);
        setpoint <= 16'h03e8;
        wait_sample(dt);
        wait_sample(dt);
        check("integral maximum", {8'h00, freq_cmd}, 32'd10000000);
        $display("test integral done");
    endtask

    task automatic t_derivative();
        int dt;
        setup('{16'h0000, 16'h0000, 16'h03e8, 16'h0014, 16'h0014, 16'h0000, 16'h0000}, 16'h0000, 16'h0000);
        wait_sample(dt);
        check("no error", {8'h00, freq_cmd}, 32'h0);
        setpoint <= 16'h0064;
        wait_sample(dt);
        check("error step", {8'h00, freq_cmd}, 32'(100 * 10000 + 100 * 10000 * TS / 1000));
        wait_sample(dt);
        check("steady error", {8'h00, freq_cmd}, 32'(2 * 100 * 10000 * TS / 1000));
        $display("test derivative done");
    endtask

    task automatic t_deadband();
        int dt;
        setup('{16'h0000, 16'h2710, 16'h03e8, 16'h0000, 16'h0014, 16'h0032, 16'h0000}, 16'h0032, 16'h0000);
        wait_sample(dt);
        check("edge of band", {8'h00, freq_cmd}, 32'h0);
        setpoint <= 16'h0064;
        wait_sample(dt);
        check("out of band", {8'h00, freq_cmd}, 32'(100 * 10000 + 100 * 10000 * TS / 1000));
        setpoint <= 16'h0032;
        wait_sample(dt);
        check("band holds", {8'h00, freq_cmd}, 32'(100 * 10000 + 100 * 10000 * TS / 1000));
        $display("test deadband done");
    endtask

    // buffering time equal to the period halves the remaining step each sample
    task automatic t_filter();
        int dt;
        setup('{16'h0000, 16'h2710, 16'h03e8, 16'h0000, 16'h0014, 16'h0000, 16'h0014}, 16'h03e8, 16'h0000);
        wait_sample(dt);
        check("filter first", {8'h00, freq_cmd}, 32'd5000000);
        wait_sample(dt);
        check("filter second", {8'h00, freq_cmd}, 32'd7500000);
        $display("test filter done");
    endtask

    // loss time 0.2 s: fault only after a third 0.1 s unit, about 300 clocks
    task automatic t_loss();
        int n;
        wr(REG_LTHR, 16'h0064);
        wr(REG_LTIME, 16'h0002);
        wr(REG_MASK, 16'h0002);
        setup('{16'h0000, 16'h0000, 16'h03e8, 16'h0000, 16'h0014, 16'h0000, 16'h0000}, 16'h0000, 16'h0064);
        repeat (250) @(posedge mclk);
        fb_level <= 16'h0096;
        repeat (20) @(posedge mclk);
        fb_level <= 16'h0064;
        repeat (250) @(posedge mclk);
        #1;
        check("timer restarted", {31'h0, loss_fault}, 32'h0);
        check("masked irq", {31'h0, irq}, 32'h0);
        n = 0;
        while (loss_fault !== 1'b1 && n < 150) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("loss fault", {31'h0, loss_fault}, 32'h1);
        check("loss irq", {31'h0, irq}, 32'h1);
        @(posedge mclk);
        fb_level <= 16'h01f4;
        repeat (3) @(posedge mclk);
        wr(REG_STAT, 16'h0002);
        @(posedge mclk);
        #1;
        check("fault cleared", {31'h0, loss_fault}, 32'h0);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr(REG_MASK, 16'h0001);
        $display("test loss done");
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        wr(REG_MASK, 16'h0001);
        t_inactive();
        t_polarity();
        t_integral();
        t_derivative();
        t_deadband();
        t_filter();
        t_loss();
        finish_test();
    end
endmodule // test_process_pid_regulator
`default_nettype wire
